// file: design/psc_buf2.sv
// Two-entry buffer with valid and ready on both sides
module psc_buf2 (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire psc_pkg::psc_word_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output psc_pkg::psc_word_t out_data_o
);
  import psc_pkg::*;

  psc_word_t mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  wire do_wr = in_valid_i && (count_r != PSC_BUF_DEPTH);
  wire do_rd = out_ready_i && (count_r != 2'h0);

  assign in_ready_o = (count_r != PSC_BUF_DEPTH);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (do_wr) begin
        mem_r[wr_ptr_r] <= in_data_i;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (do_rd) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end

  buf_full_a: assert property (@(posedge clock_i) disable iff (reset_i)
    count_r <= PSC_BUF_DEPTH)
    else $error("buffer count exceeds depth");
endmodule

// file: design/psc_pkg.sv
// Package for the parallel to serial converter: constants and carrier types
package psc_pkg;
  // ==========================================================
  // Widths and counts
  localparam int unsigned PSC_WORD_W = 4;
  localparam int unsigned PSC_CNT_W = 3;
  localparam logic [2:0] PSC_LAST4 = 3'h3;
  localparam logic [2:0] PSC_LAST8 = 3'h7;
  localparam logic [2:0] PSC_CNT_RST = 3'h0;
  localparam logic [1:0] PSC_BUF_DEPTH = 2'h2;
  localparam int unsigned PSC_DIV4_HALF = 2;
  localparam int unsigned PSC_DIV8_HALF = 4;

  // ==========================================================
  // Modes and carriers
  typedef enum logic [0:0] {
    PSC_MODE_4BIT = 1'b0,
    PSC_MODE_8BIT = 1'b1
  } psc_mode_t;

  typedef struct packed {
    logic [PSC_WORD_W-1:0] bits;
  } psc_word_t;

  typedef struct packed {
    logic div4;
    logic div8;
  } psc_clk_t;
endpackage

// file: design/psc_top.sv
// Parallel to serial converter: 4:1 or cascaded 8:1 serialiser
module psc_top (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic restart_i,
  input wire logic mode_i,
  input wire psc_pkg::psc_word_t parallel_word_in_i,
  input wire logic word_valid_i,
  output logic word_ready_o,
  input wire logic cascade_serial_in_i,
  output logic serial_line_out_o,
  output logic div4_load_clock_out_o,
  output logic div8_load_clock_out_o,
  output logic word_taken_o
);
  import psc_pkg::*;

  // ==========================================================
  // Input buffer
  psc_word_t buf_data;
  logic buf_valid;
  logic buf_ready;
  logic in_ready;
  // Pop half a cycle after the falling-edge load, so the
  // shifter never sees the buffer head move under it
  logic pop_req;

  psc_buf2 u_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(word_valid_i),
    .in_ready_o(in_ready),
    .in_data_i(parallel_word_in_i),
    .out_valid_o(buf_valid),
    .out_ready_i(pop_req),
    .out_data_o(buf_data)
  );

  // ==========================================================
  // Divider and sequence
  logic [PSC_CNT_W-1:0] cnt_r;
  logic [PSC_CNT_W-1:0] cnt_nxt;
  logic [PSC_WORD_W-1:0] shift_r;
  logic [PSC_WORD_W-1:0] shift_nxt;
  logic mode_r;
  psc_clk_t lclk_r;
  psc_clk_t lclk_nxt;
  logic serial_line_out_r;
  logic serial_line_out_nxt;
  logic taken_r;
  logic ready_r;
  logic cas_r;

  wire mode8 = (mode_r == PSC_MODE_8BIT);
  wire [PSC_CNT_W-1:0] last_cnt = mode8 ? PSC_LAST8 : PSC_LAST4;
  wire at_last = (cnt_r == last_cnt);
  wire at_load = (cnt_r == PSC_CNT_RST);
  wire [1:0] bit_pos = cnt_r[1:0];
  // Upper half of an 8-bit frame passes the cascade input through
  wire upper_half = mode8 && cnt_r[2];

  assign cnt_nxt = restart_i ? PSC_CNT_RST :
    (at_last ? PSC_CNT_RST : cnt_r + 3'h1);
  assign buf_ready = at_load && !restart_i;
  wire load_now = buf_ready && buf_valid;
  assign pop_req = taken_r;
  assign shift_nxt = load_now ? buf_data.bits : shift_r;
  assign serial_line_out_nxt = upper_half ? cas_r :
    (at_load ? (load_now ? buf_data.bits[0] : 1'b0)
             : shift_r[bit_pos]);
  assign lclk_nxt.div4 = (cnt_nxt[1:0] < 2'(PSC_DIV4_HALF));
  assign lclk_nxt.div8 = (cnt_nxt < 3'(PSC_DIV8_HALF));

  // All divider and shifter state moves on the falling edge of the bit clock; the buffer moves on the rising edge
  always_ff @(negedge clock_i) begin
    if (reset_i) begin
      cnt_r <= PSC_CNT_RST;
      shift_r <= '0;
      mode_r <= PSC_MODE_4BIT;
      lclk_r <= '0;
      serial_line_out_r <= 1'b0;
      taken_r <= 1'b0;
      ready_r <= 1'b0;
      cas_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      mode_r <= at_last ? mode_i : mode_r;
      lclk_r <= lclk_nxt;
      serial_line_out_r <= serial_line_out_nxt;
      taken_r <= load_now;
      ready_r <= in_ready;
      cas_r <= cascade_serial_in_i;
    end
  end

  assign serial_line_out_o = serial_line_out_r;
  assign div4_load_clock_out_o = lclk_r.div4;
  assign div8_load_clock_out_o = lclk_r.div8;
  assign word_taken_o = taken_r;
  assign word_ready_o = ready_r;

  // ==========================================================
  // Checks
  restart_zero_a: assert property (@(negedge clock_i) disable iff (reset_i)
    restart_i |=> cnt_r == PSC_CNT_RST)
    else $error("restart did not clear divider");
  wrap4_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (!mode8 && cnt_r == PSC_LAST4 && !restart_i) |=> cnt_r == PSC_CNT_RST)
    else $error("4-bit frame did not wrap at four");
  wrap8_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (mode8 && cnt_r == PSC_LAST8 && !restart_i) |=> cnt_r == PSC_CNT_RST)
    else $error("8-bit frame did not wrap at eight");
  count_step_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (!at_last && !restart_i) |=> cnt_r == $past(cnt_r) + 3'h1)
    else $error("divider did not advance");
  first_bit_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (at_load && buf_valid && !restart_i) |=> serial_line_out_r == $past(buf_data.bits[0]))
    else $error("lowest bit not sent first");
  later_bit_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (!at_load && !upper_half) |=> serial_line_out_r == $past(shift_r[bit_pos]))
    else $error("serial bit order wrong");
  cascade_pass_a: assert property (@(negedge clock_i) disable iff (reset_i)
    upper_half |=> serial_line_out_r == $past(cas_r))
    else $error("cascade input not passed through");
  div4_phase_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (!$past(reset_i) && cnt_r[1:0] == 2'h0) |-> div4_load_clock_out_o)
    else $error("div4 clock phase wrong");

  // ==========================================================
  // Output and state checks
  div4_level_a: assert property (@(negedge clock_i) disable iff (reset_i)
    !$past(reset_i)
    |-> div4_load_clock_out_o == (cnt_r[1:0] < 2'(PSC_DIV4_HALF)))
    else $error("div4 clock level wrong");

  div8_level_a: assert property (@(negedge clock_i) disable iff (reset_i)
    !$past(reset_i)
    |-> div8_load_clock_out_o == (cnt_r < 3'(PSC_DIV8_HALF)))
    else $error("div8 clock level wrong");

  restart_clk_a: assert property (@(negedge clock_i) disable iff (reset_i)
    restart_i
    |=> (div4_load_clock_out_o && div8_load_clock_out_o))
    else $error("load clocks not restarted");

  reset_out_a: assert property (@(negedge clock_i)
    reset_i
    |=> (!serial_line_out_o && !word_taken_o && !word_ready_o))
    else $error("outputs not cleared by reset");

  taken_load_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (at_load && buf_valid && !restart_i)
    |=> word_taken_o)
    else $error("load not flagged");

  taken_idle_a: assert property (@(negedge clock_i) disable iff (reset_i)
    !(at_load && buf_valid && !restart_i)
    |=> !word_taken_o)
    else $error("taken flagged without load");

  taken_pulse_a: assert property (@(negedge clock_i) disable iff (reset_i)
    word_taken_o
    |=> !word_taken_o)
    else $error("taken longer than one cycle");

  taken_serial_line_out_a: assert property (@(negedge clock_i) disable iff (reset_i)
    word_taken_o
    |-> serial_line_out_o == shift_r[0])
    else $error("first bit differs from loaded word");

  restart_noload_a: assert property (@(negedge clock_i) disable iff (reset_i)
    restart_i
    |=> !word_taken_o)
    else $error("word loaded during restart");

  ready_copy_a: assert property (@(negedge clock_i) disable iff (reset_i)
    1'b1
    |=> word_ready_o == $past(in_ready))
    else $error("ready does not follow buffer");

  empty_zero_a: assert property (@(negedge clock_i) disable iff (reset_i)
    (at_load && !load_now)
    |=> !serial_line_out_o)
    else $error("empty frame not zero");

  shift_load_a: assert property (@(negedge clock_i) disable iff (reset_i)
    load_now
    |=> shift_r == $past(buf_data.bits))
    else $error("shifter not loaded");

  shift_hold_a: assert property (@(negedge clock_i) disable iff (reset_i)
    !load_now
    |=> shift_r == $past(shift_r))
    else $error("shifter changed without load");

  mode_take_a: assert property (@(negedge clock_i) disable iff (reset_i)
    at_last
    |=> mode_r == $past(mode_i))
    else $error("mode not taken at frame end");

  mode_hold_a: assert property (@(negedge clock_i) disable iff (reset_i)
    !at_last
    |=> mode_r == $past(mode_r))
    else $error("mode changed inside frame");

  cnt_range4_a: assert property (@(negedge clock_i) disable iff (reset_i)
    !mode8
    |-> cnt_r <= PSC_LAST4)
    else $error("4-bit count out of range");

  cas_capture_a: assert property (@(negedge clock_i) disable iff (reset_i)
    1'b1
    |=> cas_r == $past(cascade_serial_in_i))
    else $error("cascade input not captured");
endmodule

// file: tb/psc_rx_model.sv
// Serial line receiver model for the converter bench
module psc_rx_model (
  input wire logic clock_i,
  input wire logic serial_i,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_o = 8'h00;
  // Mid-bit sample, newest bit at the top
  always @(posedge clock_i) rx_o <= {serial_i, rx_o[7:1]};
endmodule

// file: tb/testbench.sv
// Self-checking bench for the parallel to serial converter
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;
  logic clock_i, reset_i, restart_i, mode_i, word_valid_i, casc;
  psc_word_t word;
  logic ready, ser, d4, d8, taken;
  logic [7:0] rx, h4, h8;
  int err_total, n_tests, cyc, i;
  psc_top dut_u (.clock_i(clock_i), .reset_i(reset_i), .restart_i(restart_i),
    .mode_i(mode_i), .parallel_word_in_i(word), .word_valid_i(word_valid_i),
    .word_ready_o(ready), .cascade_serial_in_i(casc), .serial_line_out_o(ser),
    .div4_load_clock_out_o(d4), .div8_load_clock_out_o(d8), .word_taken_o(taken));
  psc_rx_model rx_u (.clock_i(clock_i), .serial_i(ser), .rx_o(rx));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic send(input logic [3:0] w);
    @(negedge clock_i);
    word <= w;
    word_valid_i <= 1'b1;
    @(negedge clock_i);
    word_valid_i <= 1'b0;
  endtask
  task automatic wait_load();
    i = 0;
    do begin
      @(posedge clock_i);
      i++;
    end while (taken !== 1'b1 && i < 40);
    check({7'h00, taken}, 8'h01);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  // ==========================================================
  // Scenarios
  task automatic s_four();
    @(negedge clock_i);
    @(posedge clock_i);
    check({7'h00, ready}, 8'h01);
    send(4'h9);
    wait_load();
    fork
      send(4'h6);
    join_none
    repeat (3) @(posedge clock_i);
    #1;
    check({4'h0, rx[7:4]}, 8'h09);
    @(posedge clock_i);
    check({7'h00, taken}, 8'h01);
    repeat (3) @(posedge clock_i);
    #1;
    check({4'h0, rx[7:4]}, 8'h06);
  endtask
  task automatic s_eight();
    @(negedge clock_i);
    mode_i <= 1'b1;
    casc <= 1'b1;
    repeat (12) @(negedge clock_i);
    send(4'h5);
    wait_load();
    fork
      send(4'hA);
    join_none
    for (i = 0; i < 8; i++) begin
      h4[i] = d4;
      h8[i] = d8;
      if (i < 7) @(posedge clock_i);
    end
    #1;
    check(rx, 8'hF5);
    @(posedge clock_i);
    check({7'h00, taken}, 8'h01);
    check({2'h0, h4[5:0] ^ h4[7:2]}, 8'h3F);
    check({4'h0, h8[3:0] ^ h8[7:4]}, 8'h0F);
  endtask
  task automatic s_restart();
    send(4'h3);
    @(negedge clock_i);
    restart_i <= 1'b1;
    @(negedge clock_i);
    restart_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check({7'h00, taken}, 8'h01);
    repeat (7) @(posedge clock_i);
    #1;
    check(rx, 8'hF3);
  endtask
  initial begin
    reset_i = 1'b1;
    restart_i = 1'b0;
    mode_i = 1'b0;
    word_valid_i = 1'b0;
    casc = 1'b0;
    word = 4'h0;
    repeat (6) @(negedge clock_i);
    reset_i <= 1'b0;
    s_four();
    s_eight();
    s_restart();
    complete_run();
  end
endmodule
